// File: hw/convolver_control_interface.sv
`timescale 1ns/1ps
// Overview of operation
// R1: Master drives chain strobe out during load, feeding next device's chain input.
// R2: In chained systems the chain strobe input ends the master's write strobe.
// R3: Delayed sync output copies line sync after a programmed delay.
// R4: Data strobe is active low; host drives it, EPROM master drives it out.
// R5: Register access only when chip select, read-not-write and data strobe combine.
// R6: EPROM single or master loads the lowest 72 addresses without chip select.
// R7: After power-on load, chip select starts a fresh EPROM load.
// R8: Host drives read-not-write high for reads, low for writes; tied low for EPROM.
// R9: Config update is an input normally; EPROM single/master drives it while loading.
// R10: All events on the rising clock edge, except low expansion inputs.
// R11: Clock may be multiplied by two or four for multiplier reuse.
// R12: Threshold flag high when result exceeds threshold; valid on last device only.
// R13: Gain overflow output high whenever the gain block has overflowed.
// R14: Power-on reset input is active low and resets the device.
// R15: Grounded single strap selects single-device mode; open reads inactive.
// R16: Grounded master strap selects chain master; open in single systems.
// R17: Output drivers enabled only while output enable input is low; code gates only status_oe_o with it, the other drive enables ignore it.
// R18: Master outputs a four-bit select naming one of sixteen devices.
// R19: Field select outputs report auto-selected field, coded like the field config bits.
// R20: Single/master uses coefficient bus for address and data; top bit picks EPROM.
// R21: Line delay address pointers held in reset while line sync is high.
// R22: EPROM load steps the address up from zero, one strobe per register.
module convolver_control_interface #(
    parameter int SYNC_DEPTH = 256,
    parameter int SYNC_SEL_W = 8
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // Straps and reset pin
    input wire logic por_n_i,
    input wire logic single_n_i,
    input wire logic master_n_i,
    input wire logic out_drive_en_n_i,
    // Host and chain pins
    input wire logic chip_sel_n_i,
    input wire logic rnw_i,
    input wire logic data_strobe_n_i,
    output logic data_strobe_n_o,
    output logic data_strobe_oe_o,
    input wire logic cfg_update_i,
    output logic cfg_update_o,
    output logic cfg_update_oe_o,
    input wire logic chain_strobe_in_n_i,
    output logic chain_strobe_out_n_o,
    output logic [3:0] device_select_o,
    // Coefficient bus
    input wire logic [15:0] coef_bus_i,
    output logic [6:0] coef_addr_o,
    output logic coef_addr_oe_o,
    output logic [7:0] coef_data_o,
    output logic coef_data_oe_o,
    // Video sync and status pins
    input wire logic line_sync_in_i,
    output logic delayed_sync_out_o,
    output logic threshold_flag_o,
    output logic gain_overflow_o,
    output logic [1:0] field_sel_out_o,
    output logic status_oe_o,
    // Configuration from the register file
    input wire logic [1:0] clk_mult_i,
    input wire logic [SYNC_SEL_W-1:0] sync_delay_i,
    input wire logic [3:0] chain_last_dev_i,
    // Datapath status
    input wire logic [15:0] result_i,
    input wire logic [15:0] threshold_i,
    input wire logic gain_ovf_i,
    input wire logic [1:0] auto_field_i,
    // Register file port
    input wire logic [7:0] reg_rdata_i,
    output logic [6:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_we_o,
    output logic reg_re_o,
    // Core control and mode
    output logic line_ptr_rst_o,
    output logic [1:0] mac_phase_o,
    output logic pixel_en_o,
    output logic load_busy_o,
    output logic single_o,
    output logic master_o,
    output logic eprom_mode_o,
    output logic [15:0] exp_data_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic por_s, single_n_s, master_n_s, oe_n_s, line_s;
    logic cs_n_s, rnw_s, ds_n_s, cfg_upd_s, chain_in_n_s;
    logic [15:0] coef_s;
    logic [9:0] pins_s;

    pin_sync #(.W(10), .RST_VAL(cvctl_pkg::PIN_RST)) u_ctl_sync (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .pin_i({chain_strobe_in_n_i, cfg_update_i, data_strobe_n_i, rnw_i,
                chip_sel_n_i, line_sync_in_i, out_drive_en_n_i, master_n_i,
                single_n_i, por_n_i}),
        .level_o(pins_s)
    );

    // Bus is sampled too slowly for expansion data at full rate
    pin_sync #(.W(16), .RST_VAL(16'h0000)) u_bus_sync (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .pin_i(coef_bus_i),
        .level_o(coef_s)
    );

    assign {chain_in_n_s, cfg_upd_s, ds_n_s, rnw_s, cs_n_s,
            line_s, oe_n_s, master_n_s, single_n_s, por_s} = pins_s;

    // Power-on pin held low keeps everything but the pin synchronisers in reset
    wire rst = srst_i | ~por_s; // [R14]

    ////////////////////////////////////////////////////////////////////////////
    // Straps, caught once after reset release

    logic straps_taken_reg;

    always_ff @(posedge core_clk_i) begin
        if (rst) begin
            straps_taken_reg <= 1'b0;
            single_o <= 1'b0;
            master_o <= 1'b0;
            eprom_mode_o <= 1'b0;
        end else if (!straps_taken_reg) begin
            straps_taken_reg <= 1'b1;
            single_o <= ~single_n_s; // [R15]
            master_o <= ~master_n_s & single_n_s; // [R16]
            eprom_mode_o <= coef_s[cvctl_pkg::EPROM_SEL_BIT]; // [R20]
        end
    end

    wire loader = straps_taken_reg & eprom_mode_o & (single_o | master_o);
    wire multi = master_o & (chain_last_dev_i != 4'h0);

    ////////////////////////////////////////////////////////////////////////////
    // Host access decode

    logic host_acc_reg, cs_n_prev_reg;
    wire host_acc = ~cs_n_s & ~ds_n_s & cfg_upd_s & ~loader; // [R5]
    wire host_go = host_acc & ~host_acc_reg;
    wire host_wr = host_go & ~rnw_s;
    wire host_rd = host_go & rnw_s;
    wire [6:0] host_addr = coef_s[14:8];
    wire [7:0] host_data = coef_s[7:0];
    wire cs_fell = ~cs_n_s & cs_n_prev_reg;

    ////////////////////////////////////////////////////////////////////////////
    // EPROM load sequencer

    cvctl_pkg::load_state_t state_reg, state_next;
    logic [6:0] word_reg, word_next;
    logic [3:0] dev_reg, dev_next;
    logic [7:0] cnt_reg, cnt_next;
    logic [7:0] data_reg, data_next;
    logic done_reg, done_next;
    logic ld_we;

    // Power-on load runs once; later loads wait for chip select
    wire load_start = loader & (state_reg == cvctl_pkg::LD_IDLE)
                    & (~done_reg | cs_fell); // [R6] [R7]
    wire chain_cut = multi & ~chain_in_n_s;
    wire last_dev = ~master_o | (dev_reg == chain_last_dev_i);
    wire [7:0] strobe_len = multi ? cvctl_pkg::CHAIN_WAIT_CYC
                                  : cvctl_pkg::STROBE_CYC;

    always_comb begin
        state_next = state_reg;
        word_next = word_reg;
        dev_next = dev_reg;
        cnt_next = cnt_reg;
        data_next = data_reg;
        done_next = done_reg;
        ld_we = 1'b0;
        case (state_reg)
            cvctl_pkg::LD_IDLE: begin
                if (load_start) begin
                    word_next = 7'h00;
                    dev_next = 4'h0;
                    cnt_next = cvctl_pkg::SETTLE_CYC;
                    state_next = cvctl_pkg::LD_ADDR;
                end
            end
            cvctl_pkg::LD_ADDR: begin
                if (cnt_reg == 8'h00) begin
                    data_next = coef_s[7:0];
                    cnt_next = strobe_len;
                    state_next = cvctl_pkg::LD_STROBE;
                end else begin
                    cnt_next = cnt_reg - 8'h01;
                end
            end
            cvctl_pkg::LD_STROBE: begin
                // Timeout keeps a broken chain from hanging the load
                if (cnt_reg == 8'h00 || chain_cut) begin // [R2]
                    state_next = cvctl_pkg::LD_WRITE;
                end else begin
                    cnt_next = cnt_reg - 8'h01;
                end
            end
            cvctl_pkg::LD_WRITE: begin
                ld_we = (dev_reg == 4'h0);
                cnt_next = cvctl_pkg::SETTLE_CYC;
                state_next = cvctl_pkg::LD_ADDR;
                if (word_reg == cvctl_pkg::LAST_WORD) begin // [R6]
                    word_next = 7'h00;
                    if (last_dev) begin
                        state_next = cvctl_pkg::LD_IDLE;
                        done_next = 1'b1;
                    end else begin
                        dev_next = dev_reg + 4'h1; // [R18]
                    end
                end else begin
                    word_next = word_reg + 7'h01; // [R22]
                end
            end
            default: state_next = cvctl_pkg::LD_IDLE;
        endcase
    end

    // Rising edge only throughout; low expansion latch lives elsewhere
    always_ff @(posedge core_clk_i) begin // [R10]
        if (rst) begin
            state_reg <= cvctl_pkg::LD_IDLE;
            word_reg <= 7'h00;
            dev_reg <= 4'h0;
            cnt_reg <= 8'h00;
            data_reg <= 8'h00;
            done_reg <= 1'b0;
            host_acc_reg <= 1'b0;
            cs_n_prev_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            word_reg <= word_next;
            dev_reg <= dev_next;
            cnt_reg <= cnt_next;
            data_reg <= data_next;
            done_reg <= done_next;
            host_acc_reg <= host_acc;
            cs_n_prev_reg <= cs_n_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drives and register port

    wire strobing = (state_next == cvctl_pkg::LD_STROBE);
    wire busy_next = (state_next != cvctl_pkg::LD_IDLE);

    always_ff @(posedge core_clk_i) begin
        if (rst) begin
            data_strobe_n_o <= 1'b1;
            data_strobe_oe_o <= 1'b0;
            chain_strobe_out_n_o <= 1'b1;
            cfg_update_o <= 1'b0;
            cfg_update_oe_o <= 1'b0;
            coef_addr_o <= 7'h00;
            coef_addr_oe_o <= 1'b0;
            device_select_o <= 4'h0;
            load_busy_o <= 1'b0;
        end else begin
            data_strobe_n_o <= ~strobing; // [R4]
            data_strobe_oe_o <= loader; // [R4]
            chain_strobe_out_n_o <= ~(strobing & master_o); // [R1]
            cfg_update_o <= busy_next; // [R9]
            cfg_update_oe_o <= loader; // [R9]
            coef_addr_o <= word_next; // [R22]
            coef_addr_oe_o <= loader; // [R20]
            device_select_o <= master_o ? dev_next : 4'h0; // [R18]
            load_busy_o <= busy_next;
        end
    end

    wire [6:0] acc_addr = ld_we ? word_reg : host_addr;
    wire [7:0] acc_data = ld_we ? data_reg : host_data;

    always_ff @(posedge core_clk_i) begin
        if (rst) begin
            reg_we_o <= 1'b0;
            reg_re_o <= 1'b0;
            reg_addr_o <= 7'h00;
            reg_wdata_o <= 8'h00;
            coef_data_o <= 8'h00;
            coef_data_oe_o <= 1'b0;
        end else begin
            reg_we_o <= ld_we | host_wr; // [R5]
            reg_re_o <= host_rd; // [R5]
            reg_addr_o <= acc_addr;
            reg_wdata_o <= acc_data;
            if (reg_re_o) begin
                coef_data_o <= reg_rdata_i;
            end
            coef_data_oe_o <= host_acc & rnw_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status outputs, sync and clock phases

    wire [1:0] phase_last = (clk_mult_i == cvctl_pkg::MULT_X4) ? 2'h3 :
                            (clk_mult_i == cvctl_pkg::MULT_X2) ? 2'h1 : 2'h0;
    wire phase_wrap = (mac_phase_o >= phase_last);
    wire above = $signed(result_i) > $signed(threshold_i);

    always_ff @(posedge core_clk_i) begin
        if (rst) begin
            threshold_flag_o <= 1'b0;
            gain_overflow_o <= 1'b0;
            field_sel_out_o <= 2'h0;
            status_oe_o <= 1'b0;
            line_ptr_rst_o <= 1'b1;
            mac_phase_o <= 2'h0;
            pixel_en_o <= 1'b0;
            exp_data_o <= 16'h0000;
        end else begin
            threshold_flag_o <= above; // [R12]
            gain_overflow_o <= gain_ovf_i; // [R13]
            field_sel_out_o <= auto_field_i; // [R19]
            status_oe_o <= ~oe_n_s; // [R17]
            line_ptr_rst_o <= line_s; // [R21]
            mac_phase_o <= phase_wrap ? 2'h0 : mac_phase_o + 2'h1; // [R11]
            pixel_en_o <= phase_wrap; // [R11]
            exp_data_o <= (single_o | master_o) ? 16'h0000 : coef_s; // [R20]
        end
    end

    sync_delay #(.DEPTH(SYNC_DEPTH), .SEL_W(SYNC_SEL_W)) u_sync_delay (
        .core_clk_i(core_clk_i),
        .srst_i(rst),
        .in_i(line_s),
        .sel_i(sync_delay_i),
        .out_o(delayed_sync_out_o) // [R3]
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst);

    property p_strobe_busy;
        $fell(chain_strobe_out_n_o) |-> load_busy_o && master_o;
    endproperty
    a_strobe_busy: assert property (p_strobe_busy) // [R1]
        else $error("chain strobe outside a master load");

    property p_chain_end;
        state_reg == cvctl_pkg::LD_STROBE && chain_cut
            |=> state_reg == cvctl_pkg::LD_WRITE && data_strobe_n_o;
    endproperty
    a_chain_end: assert property (p_chain_end) // [R2]
        else $error("chain input did not end the strobe");

    property p_delay_zero;
        $past(sync_delay_i) == '0 |-> delayed_sync_out_o == $past(line_s, 2);
    endproperty
    a_delay_zero: assert property (p_delay_zero) // [R3]
        else $error("delayed sync wrong at zero delay");

    property p_host_write;
        host_wr |=> reg_we_o && reg_addr_o == $past(host_addr)
                    && reg_wdata_o == $past(host_data);
    endproperty
    a_host_write: assert property (p_host_write) // [R5]
        else $error("host write not passed to registers");

    property p_read_gate;
        reg_re_o |-> $past(~cs_n_s && ~ds_n_s && rnw_s);
    endproperty
    a_read_gate: assert property (p_read_gate) // [R5]
        else $error("read without select and strobe");

    property p_load_range;
        reg_we_o && load_busy_o |-> reg_addr_o <= cvctl_pkg::LAST_WORD;
    endproperty
    a_load_range: assert property (p_load_range) // [R6]
        else $error("load wrote above the load window");

    property p_reload;
        done_reg && load_start |=> load_busy_o ##[1:14] !data_strobe_n_o;
    endproperty
    a_reload: assert property (p_reload) // [R7]
        else $error("chip select did not restart the load");

    property p_threshold;
        !$past(rst) |-> threshold_flag_o == $past(above);
    endproperty
    a_threshold: assert property (p_threshold) // [R12]
        else $error("threshold flag wrong");

    property p_overflow;
        $rose(gain_ovf_i) |=> gain_overflow_o;
    endproperty
    a_overflow: assert property (p_overflow) // [R13]
        else $error("gain overflow not shown");

    property p_out_enable;
        status_oe_o |-> !$past(oe_n_s);
    endproperty
    a_out_enable: assert property (p_out_enable) // [R17]
        else $error("drivers on with enable high");

    property p_ptr_rst;
        $rose(line_s) |=> line_ptr_rst_o;
    endproperty
    a_ptr_rst: assert property (p_ptr_rst) // [R21]
        else $error("pointer reset missed line sync");

    property p_mult_x2;
        (clk_mult_i == cvctl_pkg::MULT_X2)[*3] ##0 pixel_en_o |=> !pixel_en_o;
    endproperty
    a_mult_x2: assert property (p_mult_x2) // [R11]
        else $error("double rate enable too frequent");

    c_power_load: cover property ($fell(load_busy_o));
    c_host_read: cover property (reg_re_o);
    c_chain_cut: cover property (state_reg == cvctl_pkg::LD_STROBE && chain_cut);
endmodule

// File: include/cvctl_pkg.sv
package cvctl_pkg;
    // Core clock
    localparam int CLK_PERIOD_NS = 10;
    // Load walk
    localparam int LOAD_WORDS = 72;
    localparam logic [6:0] LAST_WORD = 7'(LOAD_WORDS - 1);
    localparam int EPROM_SEL_BIT = 15;
    // Timing: least times round up
    localparam int SETTLE_NS = 100;
    localparam int STROBE_NS = 50;
    localparam logic [7:0] SETTLE_CYC = 8'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] STROBE_CYC = 8'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] CHAIN_WAIT_CYC = 8'h40;
    // Pin synchroniser idle values
    localparam logic [9:0] PIN_RST = 10'h2ee;
    // Multiply codes
    localparam logic [1:0] MULT_X1 = 2'h0;
    localparam logic [1:0] MULT_X2 = 2'h1;
    localparam logic [1:0] MULT_X4 = 2'h2;
    typedef enum logic [1:0] {LD_IDLE, LD_ADDR, LD_STROBE, LD_WRITE} load_state_t;
endpackage

// File: hw/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // Pins and settled levels
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] level_o
);
    logic [W-1:0] s1_reg, s2_reg, s3_reg;
    wire [W-1:0] agree = ~(s2_reg ^ s3_reg);

    // A bit only moves once the second and third stages agree
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            level_o <= RST_VAL;
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_o <= (s2_reg & agree) | (level_o & ~agree);
        end
    end
endmodule

// File: hw/sync_delay.sv
`timescale 1ns/1ps
module sync_delay #(
    parameter int DEPTH = 256,
    parameter int SEL_W = 8
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // Level in, tap select, delayed level out
    input wire logic in_i,
    input wire logic [SEL_W-1:0] sel_i,
    output logic out_o
);
    logic [DEPTH-1:0] line_reg;

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            line_reg <= '0;
            out_o <= 1'b0;
        end else begin
            line_reg <= {line_reg[DEPTH-2:0], in_i};
            out_o <= line_reg[sel_i];
        end
    end
endmodule

// File: verif/eprom_chain_model.sv
`timescale 1ns/1ps
module eprom_chain_model #(
    parameter int ACCESS_CYC = 3,
    parameter int CHAIN_CYC = 20
) (
    // Clock
    input wire logic core_clk_i,
    // Address side and chain strobe from the master
    input wire logic [6:0] addr_i,
    input wire logic addr_oe_i,
    input wire logic chain_strobe_n_i,
    // Answers
    output logic [7:0] data_o,
    output logic chain_return_n_o
);
    logic [6:0] last_addr = 7'h00;
    int age = 0;
    int chain_age = 0;
    initial data_o = 8'h00;
    initial chain_return_n_o = 1'b1;
    always @(posedge core_clk_i) begin
        // Data toggles until the access time has run out
        if (!addr_oe_i || addr_i !== last_addr) begin
            age <= 0;
            data_o <= ~data_o;
        end else if (age < ACCESS_CYC) begin
            age <= age + 1;
            data_o <= ~data_o;
        end else begin
            data_o <= {1'b0, addr_i} ^ 8'ha5;
        end
        last_addr <= addr_i;
        // Slow next device, so the return visibly ends the strobe
        if (chain_strobe_n_i) begin
            chain_age <= 0;
        end else begin
            chain_age <= chain_age + 1;
        end
        chain_return_n_o <= !(!chain_strobe_n_i && chain_age >= CHAIN_CYC);
    end
endmodule

// File: verif/testbench.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp); end end
module testbench;
    logic core_clk_i = 0, srst_i = 1, por_n_i = 0, single_n_i = 0, master_n_i = 1;
    logic out_drive_en_n_i = 1, chip_sel_n_i = 1, rnw_i = 0, ds_drv_n = 1, cfg_drv = 0;
    logic line_sync_in_i = 0, gain_ovf_i = 0, eprom_sel = 0;
    logic [1:0] clk_mult_i = 2'h0, auto_field_i = 2'h0;
    logic [7:0] sync_delay_i = 8'h03, reg_rdata_i = 8'h00, ep_data;
    logic [3:0] chain_last_dev_i = 4'h0, device_select_o, dev_max;
    logic [15:0] result_i = 16'h0000, threshold_i = 16'h0000, exp_data_o;
    logic [14:0] host_bus = 15'h0000;
    logic data_strobe_n_o, data_strobe_oe_o, cfg_update_o, cfg_update_oe_o, chain_in_n;
    logic chain_strobe_out_n_o, coef_addr_oe_o, coef_data_oe_o, delayed_sync_out_o;
    logic threshold_flag_o, gain_overflow_o, status_oe_o, reg_we_o, reg_re_o;
    logic line_ptr_rst_o, pixel_en_o, load_busy_o, single_o, master_o, eprom_mode_o;
    logic [6:0] coef_addr_o, reg_addr_o;
    logic [7:0] coef_data_o, reg_wdata_o;
    logic [1:0] field_sel_out_o, mac_phase_o;
    wire logic [15:0] coef_bus_i = {eprom_sel, coef_addr_oe_o ? coef_addr_o : host_bus[14:8],
                                    eprom_sel ? ep_data : host_bus[7:0]};
    wire logic data_strobe_n_i = data_strobe_oe_o ? data_strobe_n_o : ds_drv_n;
    wire logic cfg_update_i = cfg_update_oe_o ? cfg_update_o : cfg_drv;
    int fail_count = 0, n_checks = 0, cycles = 0, ds_falls, chain_falls, chain_w, chain_wmax;
    logic [6:0] wr_addr[$];
    logic [7:0] wr_data[$];
    logic ds_q = 1, ch_q = 1;

    always #5 core_clk_i = ~core_clk_i;

    convolver_control_interface dut_u (.core_clk_i, .srst_i, .por_n_i, .single_n_i,
        .master_n_i, .out_drive_en_n_i, .chip_sel_n_i, .rnw_i, .data_strobe_n_i,
        .data_strobe_n_o, .data_strobe_oe_o, .cfg_update_i, .cfg_update_o, .cfg_update_oe_o,
        .chain_strobe_in_n_i(chain_in_n), .chain_strobe_out_n_o, .device_select_o,
        .coef_bus_i, .coef_addr_o, .coef_addr_oe_o, .coef_data_o, .coef_data_oe_o,
        .line_sync_in_i, .delayed_sync_out_o, .threshold_flag_o, .gain_overflow_o,
        .field_sel_out_o, .status_oe_o, .clk_mult_i, .sync_delay_i, .chain_last_dev_i,
        .result_i, .threshold_i, .gain_ovf_i, .auto_field_i, .reg_rdata_i, .reg_addr_o,
        .reg_wdata_o, .reg_we_o, .reg_re_o, .line_ptr_rst_o, .mac_phase_o, .pixel_en_o,
        .load_busy_o, .single_o, .master_o, .eprom_mode_o, .exp_data_o);

    eprom_chain_model model_u (.core_clk_i, .addr_i(coef_addr_o), .addr_oe_i(coef_addr_oe_o),
        .chain_strobe_n_i(chain_strobe_out_n_o), .data_o(ep_data), .chain_return_n_o(chain_in_n));

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk_i) begin
        cycles++;
        ds_q <= data_strobe_n_o;
        ch_q <= chain_strobe_out_n_o;
        if (reg_we_o === 1'b1) begin
            wr_addr.push_back(reg_addr_o);
            wr_data.push_back(reg_wdata_o);
        end
        if (ds_q === 1'b1 && data_strobe_n_o === 1'b0) ds_falls++;
        if (ch_q === 1'b1 && chain_strobe_out_n_o === 1'b0) chain_falls++;
        chain_w = (chain_strobe_out_n_o === 1'b0) ? chain_w + 1 : 0;
        if (chain_w > chain_wmax) chain_wmax = chain_w;
        if (device_select_o > dev_max) dev_max = device_select_o;
        if (cycles == 40000) begin
            fail_count++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic clear_mon();
        wr_addr.delete();
        wr_data.delete();
        ds_falls = 0;
        chain_falls = 0;
        chain_wmax = 0;
        dev_max = 4'h0;
    endtask

    task automatic do_reset(input logic ep, input logic sn, input logic mn);
        @(negedge core_clk_i);
        srst_i = 1;
        por_n_i = 0;
        eprom_sel = ep;
        single_n_i = sn;
        master_n_i = mn;
        repeat (5) @(negedge core_clk_i);
        `CHK(data_strobe_oe_o, 1'b0)
        `CHK(load_busy_o, 1'b0)
        clear_mon();
        srst_i = 0;
        por_n_i = 1;
        repeat (8) @(negedge core_clk_i);
    endtask

    task automatic host_access(input logic rd, input logic [6:0] a, input logic [7:0] d,
                               input logic strobe);
        int i;
        @(negedge core_clk_i);
        chip_sel_n_i = 0;
        rnw_i = rd;
        ds_drv_n = !strobe;
        cfg_drv = 1;
        host_bus = {a, d};
        reg_rdata_i = d;
        for (i = 0; i < 10 && reg_we_o !== 1'b1 && reg_re_o !== 1'b1; i++) @(negedge core_clk_i);
        if (strobe) begin
            `CHK(rd ? reg_re_o : reg_we_o, 1'b1)
            `CHK(reg_addr_o, a)
            if (!rd) `CHK(reg_wdata_o, d)
            @(negedge core_clk_i);
            `CHK(rd ? reg_re_o : reg_we_o, 1'b0)
            if (rd) `CHK(coef_data_o, d)
            `CHK(coef_data_oe_o, rd)
        end else `CHK(reg_we_o | reg_re_o, 1'b0)
        chip_sel_n_i = 1;
        ds_drv_n = 1;
        cfg_drv = 0;
        rnw_i = 0;
        repeat (6) @(negedge core_clk_i);
    endtask

    task automatic run_load(input int strobes);
        int i;
        for (i = 0; i < 30 && load_busy_o !== 1'b1; i++) @(negedge core_clk_i);
        `CHK(cfg_update_oe_o, 1'b1)
        `CHK(cfg_update_o, 1'b1)
        `CHK(data_strobe_oe_o, 1'b1)
        for (i = 0; i < 12000 && (load_busy_o | reg_we_o) !== 1'b0; i++) @(negedge core_clk_i);
        `CHK(wr_addr.size(), 72)
        for (i = 0; i < wr_addr.size(); i++) begin
            `CHK(wr_addr[i], 7'(i))
            `CHK(wr_data[i], {1'b0, 7'(i)} ^ 8'ha5)
        end
        `CHK(ds_falls, strobes)
    endtask

    task automatic sync_lag(input logic [7:0] tap, output int lag);
        sync_delay_i = tap;
        repeat (20) @(negedge core_clk_i);
        line_sync_in_i = 1;
        for (lag = 0; lag < 60 && delayed_sync_out_o !== 1'b1; lag++) @(negedge core_clk_i);
        repeat (6) @(negedge core_clk_i);
        `CHK(line_ptr_rst_o, 1'b1)
        line_sync_in_i = 0;
        repeat (20) @(negedge core_clk_i);
        `CHK(line_ptr_rst_o, 1'b0)
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int k, cnt, lag_a, lag_b;
        do_reset(1'b0, 1'b0, 1'b1);
        `CHK(single_o, 1'b1)
        `CHK({eprom_mode_o, exp_data_o}, 17'h0)
        host_access(1'b0, 7'h47, 8'h3c, 1'b1);
        host_access(1'b1, 7'h05, 8'hc3, 1'b1);
        host_access(1'b0, 7'h10, 8'h99, 1'b0);
        // Signed compare: positive result over negative threshold
        result_i = 16'h0010;
        threshold_i = 16'hfff0;
        gain_ovf_i = 1;
        out_drive_en_n_i = 0;
        repeat (8) @(negedge core_clk_i);
        `CHK(threshold_flag_o, 1'b1)
        `CHK(gain_overflow_o, 1'b1)
        `CHK(status_oe_o, 1'b1)
        result_i = 16'h8000;
        threshold_i = 16'h0000;
        gain_ovf_i = 0;
        out_drive_en_n_i = 1;
        repeat (8) @(negedge core_clk_i);
        `CHK(threshold_flag_o, 1'b0)
        `CHK(gain_overflow_o, 1'b0)
        `CHK(status_oe_o, 1'b0)
        for (k = 0; k < 4; k++) begin
            auto_field_i = 2'(k);
            repeat (2) @(negedge core_clk_i);
            `CHK(field_sel_out_o, 2'(k))
        end
        for (k = 0; k < 3; k++) begin
            clk_mult_i = 2'(k);
            repeat (8) @(negedge core_clk_i);
            cnt = 0;
            repeat (16) begin
                @(negedge core_clk_i);
                cnt += (pixel_en_o === 1'b1);
            end
            `CHK(cnt, 16 >> k)
        end
        sync_lag(8'h00, lag_a);
        sync_lag(8'h06, lag_b);
        `CHK(lag_b - lag_a, 6)
        // Single device fed from the EPROM
        do_reset(1'b1, 1'b0, 1'b1);
        `CHK(eprom_mode_o, 1'b1)
        run_load(72);
        for (k = 0; k < 2; k++) begin
            clear_mon();
            chip_sel_n_i = 0;
            repeat (4) @(negedge core_clk_i);
            chip_sel_n_i = 1;
            if (k == 0) run_load(72);
        end
        // Reset pin pulled in the middle of a reload
        repeat (40) @(negedge core_clk_i);
        por_n_i = 0;
        repeat (8) @(negedge core_clk_i);
        `CHK(load_busy_o, 1'b0)
        `CHK(line_ptr_rst_o, 1'b1)
        // Chain master with two devices
        chain_last_dev_i = 4'h1;
        do_reset(1'b1, 1'b1, 1'b0);
        `CHK(master_o, 1'b1)
        run_load(144);
        `CHK(dev_max, 4'h1)
        `CHK(chain_falls, 144)
        `CHK(chain_wmax > 20 && chain_wmax < 40, 1'b1)
        summarize();
    end
endmodule
